/* pkg/pgsc_pkg.sv */
// pgsc_pkg: shared types and constants of the power-good start-up control block.
// assumes one reference clock domain; pins arrive asynchronously and are synchronised.

package pgsc_pkg;

	// ----------------------------------------
	// pin function chosen by the configuration
	// ----------------------------------------
	typedef enum logic [1:0] {
		PGSC_MODE_NONE = 2'h0,
		PGSC_MODE_SLEEP = 2'h1,
		PGSC_MODE_REINIT = 2'h2
	} pgsc_mode_type;

	// raw code with both pin functions set; never a legal configuration
	localparam logic [1:0] PGSC_MODE_BOTH = 2'h3;

	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		PGSC_ST_WAIT = 3'h0,
		PGSC_ST_HOLD = 3'h1,
		PGSC_ST_LOAD = 3'h2,
		PGSC_ST_RUN = 3'h3,
		PGSC_ST_SLEEP = 3'h4,
		PGSC_ST_RESTART = 3'h5
	} pgsc_state_type;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	localparam int PGSC_SEL_W = 2;

	typedef struct packed {
		logic good_pin_level;
		logic supplies_valid_level;
		logic [PGSC_SEL_W-1:0] cfg_sel;
	} pgsc_pins_type;

	typedef struct packed {
		logic req;
		logic from_eeprom;
		logic [PGSC_SEL_W-1:0] sel;
	} pgsc_load_type;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam pgsc_pins_type PGSC_PINS_RST = '{1'b0, 1'b0, 2'h0};
	localparam pgsc_load_type PGSC_LOAD_RST = '{1'b0, 1'b0, 2'h0};
	localparam logic PGSC_FLAG_RST = 1'b0;

endpackage : pgsc_pkg

/* hdl/pgsc_sync.sv */
// pgsc_sync: two-stage synchroniser for the asynchronous pin inputs.
// assumes each bit is quasi-static; selection bits are only used once settled.

module pgsc_sync
	import pgsc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire pgsc_pins_type pins_raw,
	output pgsc_pins_type pins_sync
);

	// ----------------------------------------
	// stages
	// ----------------------------------------
	pgsc_pins_type meta_q;
	pgsc_pins_type sync_q;

	// first stage feeds only the second one
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_q <= PGSC_PINS_RST;
			sync_q <= PGSC_PINS_RST;
		end else begin
			meta_q <= pins_raw;
			sync_q <= meta_q;
		end
	end

	assign pins_sync = sync_q;

endmodule : pgsc_sync

/* hdl/pgsc_top.sv */
// pgsc_top: start-up and power-state sequencer driven by the power-good pin.
// assumes the configuration loader answers a load request with load_done.

module pgsc_top
	import pgsc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire pgsc_pins_type pins_raw,
	input wire logic [1:0] pin_mode_cfg,
	input wire logic eeprom_code_ok,
	input wire logic load_done,
	output pgsc_load_type load,
	output logic outputs_enable,
	output logic pll_enable,
	output logic low_power,
	output logic core_reset
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// both functions set is treated as restart, the safer of the two
	function automatic pgsc_mode_type pgsc_eff_mode(input logic [1:0] raw);
		pgsc_mode_type m;
		m = PGSC_MODE_NONE;
		case (raw)
			PGSC_MODE_SLEEP: m = PGSC_MODE_SLEEP;
			PGSC_MODE_REINIT: m = PGSC_MODE_REINIT;
			PGSC_MODE_BOTH: m = PGSC_MODE_REINIT;
			default: m = PGSC_MODE_NONE;
		endcase
		return m;
	endfunction : pgsc_eff_mode

	// where a high pin leads: reload unless sleep mode already holds a config
	function automatic pgsc_state_type pgsc_on_high(input pgsc_mode_type m, input logic loaded);
		pgsc_state_type s;
		s = PGSC_ST_LOAD;
		if ((m == PGSC_MODE_SLEEP) && loaded) begin
			s = PGSC_ST_RUN;
		end
		return s;
	endfunction : pgsc_on_high

	// ----------------------------------------
	// synchronised pins
	// ----------------------------------------
	pgsc_pins_type pins_s;
	pgsc_mode_type mode;
	logic pin_hi;

	pgsc_sync u_sync (
		.clock(clock),
		.rst(rst),
		.pins_raw(pins_raw),
		.pins_sync(pins_s)
	);

	assign mode = pgsc_eff_mode(pin_mode_cfg);
	assign pin_hi = pins_s.good_pin_level;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	pgsc_state_type state_q;
	pgsc_state_type state_d;
	logic loaded_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			PGSC_ST_WAIT: begin
				if (mode != PGSC_MODE_NONE) begin
					state_d = PGSC_ST_HOLD;
				end else if (pins_s.supplies_valid_level) begin
					state_d = PGSC_ST_LOAD;
				end
			end
			PGSC_ST_HOLD: begin
				if (pin_hi) begin
					state_d = pgsc_on_high(mode, loaded_q);
				end
			end
			PGSC_ST_LOAD: begin
				if ((mode == PGSC_MODE_REINIT) && !pin_hi) begin
					state_d = PGSC_ST_RESTART;
				end else if (load_done) begin
					state_d = PGSC_ST_RUN;
				end
			end
			PGSC_ST_RUN: begin
				if ((mode == PGSC_MODE_SLEEP) && !pin_hi) begin
					state_d = PGSC_ST_SLEEP;
				end else if ((mode == PGSC_MODE_REINIT) && !pin_hi) begin
					state_d = PGSC_ST_RESTART;
				end
			end
			PGSC_ST_SLEEP: begin
				if (pin_hi) begin
					state_d = PGSC_ST_RUN;
				end
			end
			PGSC_ST_RESTART: begin
				if (pin_hi) begin
					state_d = PGSC_ST_LOAD;
				end
			end
			default: state_d = PGSC_ST_WAIT;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= PGSC_ST_WAIT;
		end else begin
			state_q <= state_d;
		end
	end

	// loaded configuration survives sleep; a restart discards it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			loaded_q <= PGSC_FLAG_RST;
		end else if (state_d == PGSC_ST_RESTART) begin
			loaded_q <= PGSC_FLAG_RST;
		end else if ((state_q == PGSC_ST_LOAD) && (state_d == PGSC_ST_RUN)) begin
			loaded_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// load request
	// ----------------------------------------
	pgsc_load_type load_q;

	// one pulse per entry into load, so a long high never reloads twice
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			load_q <= PGSC_LOAD_RST;
		end else begin
			load_q.req <= (state_d == PGSC_ST_LOAD) && (state_q != PGSC_ST_LOAD);
			if ((state_d == PGSC_ST_LOAD) && (state_q != PGSC_ST_LOAD)) begin
				load_q.from_eeprom <= eeprom_code_ok;
				load_q.sel <= pins_s.cfg_sel;
			end
		end
	end

	assign load = load_q;

	// ----------------------------------------
	// power controls
	// ----------------------------------------
	logic outputs_enable_q;
	logic pll_enable_q;
	logic low_power_q;
	logic core_reset_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			outputs_enable_q <= PGSC_FLAG_RST;
			pll_enable_q <= PGSC_FLAG_RST;
		end else begin
			outputs_enable_q <= (state_d == PGSC_ST_RUN);
			pll_enable_q <= (state_d == PGSC_ST_LOAD) || (state_d == PGSC_ST_RUN);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			low_power_q <= PGSC_FLAG_RST;
			core_reset_q <= PGSC_FLAG_RST;
		end else begin
			low_power_q <= (state_d == PGSC_ST_SLEEP);
			core_reset_q <= (state_d == PGSC_ST_RESTART);
		end
	end

	assign outputs_enable = outputs_enable_q;
	assign pll_enable = pll_enable_q;
	assign low_power = low_power_q;
	assign core_reset = core_reset_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence seq_first_high;
		(state_q == PGSC_ST_HOLD) && pin_hi && !loaded_q;
	endsequence

	sequence seq_sleep_high;
		(state_q == PGSC_ST_SLEEP) && pin_hi;
	endsequence

	sequence seq_run_low;
		(state_q == PGSC_ST_RUN) && !pin_hi;
	endsequence

	eeprom_gate_a: assert property (load_q.req |-> load_q.from_eeprom == $past(eeprom_code_ok))
		else $error("eeprom source does not follow the configuration code");

	supply_gate_a: assert property ((state_q == PGSC_ST_WAIT) && (mode == PGSC_MODE_NONE)
		&& !pins_s.supplies_valid_level |=> !outputs_enable_q)
		else $error("outputs enabled before supplies valid");

	hold_pause_a: assert property ((state_q == PGSC_ST_HOLD) && !pin_hi |=>
		(state_q == PGSC_ST_HOLD) && !load_q.req && !outputs_enable_q)
		else $error("start-up moved on while pin low");

	power_up_a: assert property ((state_q == PGSC_ST_LOAD) && load_done && pin_hi |=>
		outputs_enable_q && pll_enable_q)
		else $error("power-up not completed on high pin");

	first_load_a: assert property (seq_first_high |=> load_q.req
		&& (load_q.sel == $past(pins_s.cfg_sel)))
		else $error("first high did not load selected config");

	no_reload_a: assert property (seq_sleep_high |=> (state_q == PGSC_ST_RUN)
		&& !load_q.req ##1 !load_q.req)
		else $error("wake from sleep reloaded a config");

	sleep_entry_a: assert property (seq_run_low ##0 (mode == PGSC_MODE_SLEEP) |=>
		low_power_q && !pll_enable_q && !outputs_enable_q)
		else $error("low pin did not enter low power");

	resume_a: assert property (seq_sleep_high |=> loaded_q && $stable(load_q.sel)
		&& outputs_enable_q && pll_enable_q)
		else $error("wake did not resume previous state");

	restart_a: assert property (seq_run_low ##0 (mode == PGSC_MODE_REINIT) |=>
		core_reset_q && !loaded_q && !outputs_enable_q)
		else $error("low pin did not reset the core");

	// a pin that drops again right after release may legally restart once more
	fresh_load_a: assert property ((state_q == PGSC_ST_RESTART) && pin_hi |=>
		load_q.req && pll_enable_q && !core_reset_q)
		else $error("restart release did not load fresh config");

	mode_excl_a: assert property (!(low_power_q && core_reset_q)
		&& (low_power_q -> (mode == PGSC_MODE_SLEEP))
		&& (core_reset_q -> (mode == PGSC_MODE_REINIT)))
		else $error("both pin functions active");

	single_load_a: assert property (load_q.req |=> !load_q.req)
		else $error("load request longer than one cycle");

endmodule : pgsc_top

/* tb/pgsc_ctrl_model.sv */
// pgsc_ctrl_model: configuration loader on the far side of the load handshake.
// assumes one clock; answers each load request after delay cycles (delay >= 1).

module pgsc_ctrl_model
	import pgsc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire pgsc_load_type load,
	input wire logic [3:0] delay,
	output logic load_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_q;

	// ----------------------------------------
	// loader answer
	// ----------------------------------------
	// a zero delay would never answer, so the bench keeps delay at one or more
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
			load_done <= 1'b0;
		end else begin
			load_done <= (cnt_q == 4'h1);
			if (load.req) begin
				cnt_q <= delay;
			end else if (cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule : pgsc_ctrl_model

/* tb/tb_top.sv */
// tb_top: self-checking bench of the power-good start-up sequencer.
// assumes pgsc_top and the loader model; load requests are checked from a queue of notes.

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import pgsc_pkg::*;

	logic clock = 1'b0;
	logic rst = 1'b1;
	pgsc_pins_type pins_raw = PGSC_PINS_RST;
	logic [1:0] pin_mode_cfg = 2'h0;
	logic eeprom_code_ok = 1'b0;
	logic [3:0] delay = 4'h1;
	logic load_done;
	pgsc_load_type load;
	logic outputs_enable;
	logic pll_enable;
	logic low_power;
	logic core_reset;
	logic [3:0] exp_q[$];
	int fails = 0;
	int n_tests = 0;

	pgsc_top i_pgsc_top (.clock(clock), .rst(rst), .pins_raw(pins_raw),
		.pin_mode_cfg(pin_mode_cfg), .eeprom_code_ok(eeprom_code_ok), .load_done(load_done),
		.load(load), .outputs_enable(outputs_enable), .pll_enable(pll_enable),
		.low_power(low_power), .core_reset(core_reset));
	pgsc_ctrl_model i_pgsc_ctrl_model (.clock(clock), .rst(rst), .load(load), .delay(delay),
		.load_done(load_done));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("tests=%0d fails=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc

	// {outputs_enable, pll_enable, low_power, core_reset}
	task automatic outs(input logic [3:0] e);
		chk({4'h0, outputs_enable, pll_enable, low_power, core_reset}, {4'h0, e});
	endtask : outs

	// pin starts low from power-up, so the controller duty is kept here
	task automatic go(input logic [1:0] m);
		rst = 1'b1;
		pin_mode_cfg = m;
		pins_raw = PGSC_PINS_RST;
		cyc(6);
		rst = 1'b0;
		cyc(2);
	endtask : go

	task automatic up(input logic sup);
		logic [PGSC_SEL_W-1:0] s;
		s = PGSC_SEL_W'($urandom);
		pins_raw.cfg_sel = s;
		eeprom_code_ok = 1'($urandom);
		delay = 4'h1 + 4'($urandom % 9);
		exp_q.push_back({1'b1, eeprom_code_ok, s});
		if (sup) pins_raw.supplies_valid_level = 1'b1;
		else pins_raw.good_pin_level = 1'b1;
		cyc(25);
	endtask : up

	// ----------------------------------------
	// result watcher
	// ----------------------------------------
	always @(posedge clock) begin
		#2;
		if (load.req === 1'b1) begin
			if (exp_q.size() == 0) chk(8'(load), 8'hFF);
			else chk(8'(load), 8'(exp_q.pop_front()));
		end
	end

	initial forever #50 clock = ~clock;

	// full run is a few hundred cycles; this leaves ample margin
	initial begin
		#(3000 * 100);
		fails++;
		summarize();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(81453));
		go(PGSC_MODE_NONE);
		pins_raw.good_pin_level = 1'b1;
		cyc(10);
		outs(4'h0);
		up(1'b1);
		outs(4'hC);
		go(PGSC_MODE_SLEEP);
		cyc(10);
		outs(4'h0);
		up(1'b0);
		outs(4'hC);
		for (int i = 0; i < 2; i++) begin
			pins_raw.good_pin_level = 1'b0;
			cyc(6);
			outs(4'h2);
			pins_raw.cfg_sel = PGSC_SEL_W'($urandom);
			pins_raw.good_pin_level = 1'b1;
			cyc(6);
			outs(4'hC);
		end
		// code 3 must act as one function only, the restart one
		for (int m = 2; m < 4; m++) begin
			go(2'(m));
			up(1'b0);
			outs(4'hC);
			pins_raw.good_pin_level = 1'b0;
			cyc(6);
			outs(4'h1);
			up(1'b0);
			outs(4'hC);
		end
		cyc(4);
		chk(8'(exp_q.size()), 8'h00);
		summarize();
	end
endmodule : tb_top
